// file: bench/pcas_clock_align_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// watches bus answers and per-channel outputs of the block
module pcas_clock_align_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       we_i,
  input wire logic       ack_o,
  input wire logic       err_o,
  input wire logic [7:0] chan_tick_o,
  input wire logic [7:0] chan_center_o,
  input wire logic [3:0] pair_join_bit_o
);
  logic [7:0] odd_mask;
  // odd channel positions of joined pairs
  assign odd_mask = {pair_join_bit_o[3], 1'b0, pair_join_bit_o[2], 1'b0,
                     pair_join_bit_o[1], 1'b0, pair_join_bit_o[0], 1'b0};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request pending and accepted write answer
  sequence s_req; cyc_i && stb_i && !ack_o && !err_o; endsequence
  sequence s_wr_ack; ack_o && we_i; endsequence
  property p_answer; s_req |=> (ack_o ^ err_o); endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_err_pulse; err_o |-> !ack_o ##1 !err_o; endproperty
  property p_join_tick; ((chan_tick_o ^ {chan_tick_o[6:0], 1'b0}) & odd_mask) == 8'h00; endproperty
  property p_join_align; ((chan_center_o ^ {chan_center_o[6:0], 1'b0}) & odd_mask) == 8'h00; endproperty
  property p_center_src; !$stable(chan_center_o) |-> s_wr_ack; endproperty
  property p_join_src; !$stable(pair_join_bit_o) |-> s_wr_ack; endproperty
  property p_reset_tick; $fell(rst_i) |-> chan_tick_o == 8'hFF; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_err_pulse: assert property (p_err_pulse) else $error("err wrong");
  a_join_tick: assert property (p_join_tick) else $error("joined tick differs");
  a_join_align: assert property (p_join_align) else $error("joined align differs");
  a_center_src: assert property (p_center_src) else $error("align moved alone");
  a_join_src: assert property (p_join_src) else $error("join moved alone");
  a_reset_tick: assert property (p_reset_tick) else $error("code zero not every cycle");
endmodule : pcas_clock_align_assertions
bind pcas_clock_align pcas_clock_align_assertions pcas_clock_align_assertions_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o),
  .err_o(err_o), .chan_tick_o(chan_tick_o), .chan_center_o(chan_center_o),
  .pair_join_bit_o(pair_join_bit_o));
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, e;
  logic [7:0]  adr_i, chan_tick_o, chan_center_o;
  logic [3:0]  sel_i, pair_join_bit_o;
  logic [31:0] dat_i, dat_o, rd;
  logic [7:0]  pre [2] = '{8'h21, 8'h73};
  int          fails, compares, n;
  pcas_clock_align pcas_clock_align_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .chan_tick_o(chan_tick_o), .chan_center_o(chan_center_o),
    .pair_join_bit_o(pair_join_bit_o));
  // bus clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // counts, verdict and end of run
  task automatic wrap_up;
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // compares one value
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fails++;
      $display("wrong value %s: expected %0h seen %0h", nm, x, g);
    end
  endtask : chk
  // one classic wishbone cycle, bounded wait for ack or err
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 20);
    rd = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1 && e !== 1'b1) begin
      fails++;
      wrap_up();
    end
  endtask : wb
  // counts ticks of one channel over a window
  task automatic cnt(input int c, input int w);
    n = 0;
    repeat (w) begin
      @(posedge clk_i);
      if (chan_tick_o[c] === 1'b1) n++;
    end
  endtask : cnt
  // main sequence
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    $display("test reset done");
    wb(1'b1, 8'h04, 32'hFF);
    wb(1'b0, 8'h04, 32'h0);
    chk("prescale", 32'h77, rd);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 8'h04, {24'h0, pre[i]});
      for (int c = 0; c < 8; c++) begin
        cnt(c, 256);
        chk("prescaled ticks", 256 >> (c[1] ? pre[i][6:4] : pre[i][2:0]), n);
      end
    end
    $display("test prescale done");
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h0C, 32'h2);
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h00, 32'h0F);
    for (int c = 0; c < 8; c++) begin
      cnt(c, 512);
      chk("scaled ticks", c > 3 ? 512 : (c[1] ? 1 : 128), n);
    end
    wb(1'b1, 8'h00, 32'h01);
    wb(1'b1, 8'h14, 32'h1);
    cnt(0, 512);
    chk("joined ticks", 512, n);
    $display("test scale done");
    wb(1'b1, 8'h14, 32'h0);
    wb(1'b1, 8'h08, 32'hA5); // every channel keeps ticking while alignment is written
    chk("center", 32'hA5, {24'h0, chan_center_o});
    wb(1'b1, 8'h14, 32'hF);
    chk("pair join", 32'hF, {28'h0, pair_join_bit_o});
    chk("joined center", 32'hF0, {24'h0, chan_center_o});
    wb(1'b1, 8'h40, 32'hFF);
    chk("unmapped err", 32'h1, {31'h0, e});
    sel_i <= 4'hE;
    wb(1'b1, 8'h08, 32'h0); // lane 0 off, write must be dropped
    sel_i <= 4'hF;
    wb(1'b0, 8'h08, 32'h0);
    chk("align readback", 32'hA5, rd);
    $display("test align done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire

// file: rtl/pcas_clock_align.sv
`timescale 1ns/1ps
`include "pcas_regs.svh"
`default_nettype none
module pcas_clock_align
  import pcas_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  output logic [7:0]       chan_tick_o,
  output logic [7:0]       chan_center_o,
  output logic [3:0]       pair_join_bit_o
);

  pcas_bus_state_t bus_q;
  pcas_bus_state_t bus_d;
  pcas_wb_req_t    req;
  logic [7:0]      src_sel_q;
  logic [7:0]      src_sel_d;
  logic [7:0]      prescale_q;
  logic [7:0]      prescale_d;
  logic [7:0]      align_q;
  logic [7:0]      align_d;
  logic [7:0]      scale_a_q;
  logic [7:0]      scale_a_d;
  logic [7:0]      scale_b_q;
  logic [7:0]      scale_b_d;
  logic [3:0]      join_q;
  logic [3:0]      join_d;
  logic [31:0]     rdat_q;
  logic [31:0]     rdat_d;
  logic            err_q;
  logic            err_d;
  logic            wr_a;
  logic            wr_b;
  logic            tick_a;
  logic            tick_b;
  logic            tick_sa;
  logic            tick_sb;
  pcas_chan_ctl_t  ctl [8];

  // true when the address is one of the six mapped words
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `PCAS_ADDR_CLK_SEL) || (a == `PCAS_ADDR_PRESCALE) ||
                  (a == `PCAS_ADDR_ALIGN) || (a == `PCAS_ADDR_SCALE_A) ||
                  (a == `PCAS_ADDR_SCALE_B) || (a == `PCAS_ADDR_PAIR_JOIN);
  endfunction : addr_mapped

  // byte lane 0 write strobe for a given address
  function automatic logic lane0_write(input pcas_wb_req_t r, input logic go, input logic [7:0] a);
    lane0_write = go && r.we && r.sel[0] && (r.adr == a);
  endfunction : lane0_write

  always_comb begin
    req.adr = adr_i;
    req.we  = we_i;
    req.sel = sel_i;
    req.dat = dat_i;
  end

  // bus slave: one wait state, ack in the second cycle, dropped after one cycle
  always_comb begin
    bus_d      = bus_q;
    src_sel_d  = src_sel_q;
    prescale_d = prescale_q;
    align_d    = align_q;
    scale_a_d  = scale_a_q;
    scale_b_d  = scale_b_q;
    join_d     = join_q;
    rdat_d     = rdat_q;
    err_d      = 1'b0;
    wr_a       = 1'b0;
    wr_b       = 1'b0;
    unique case (bus_q)
      PCAS_BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          bus_d = PCAS_BUS_ACK;
          err_d = !addr_mapped(req.adr);
          if (lane0_write(req, 1'b1, `PCAS_ADDR_CLK_SEL)) begin
            src_sel_d = req.dat[7:0];
          end
          if (lane0_write(req, 1'b1, `PCAS_ADDR_PRESCALE)) begin
            prescale_d = req.dat[7:0] & `PCAS_PRE_MASK;
          end
          if (lane0_write(req, 1'b1, `PCAS_ADDR_ALIGN)) begin
            align_d = req.dat[7:0];
          end
          if (lane0_write(req, 1'b1, `PCAS_ADDR_SCALE_A)) begin
            scale_a_d = req.dat[7:0];
            wr_a      = 1'b1;
          end
          if (lane0_write(req, 1'b1, `PCAS_ADDR_SCALE_B)) begin
            scale_b_d = req.dat[7:0];
            wr_b      = 1'b1;
          end
          if (lane0_write(req, 1'b1, `PCAS_ADDR_PAIR_JOIN)) begin
            join_d = req.dat[3:0];
          end
          unique case (req.adr)
            `PCAS_ADDR_CLK_SEL:   rdat_d = {24'h000000, src_sel_q};
            `PCAS_ADDR_PRESCALE:  rdat_d = {24'h000000, prescale_q};
            `PCAS_ADDR_ALIGN:     rdat_d = {24'h000000, align_q};
            `PCAS_ADDR_SCALE_A:   rdat_d = {24'h000000, scale_a_q};
            `PCAS_ADDR_SCALE_B:   rdat_d = {24'h000000, scale_b_q};
            `PCAS_ADDR_PAIR_JOIN: rdat_d = {28'h0000000, join_q};
            default:              rdat_d = 32'h00000000;
          endcase
        end
      end
      PCAS_BUS_ACK: begin
        bus_d = PCAS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q      <= PCAS_BUS_IDLE;
      src_sel_q  <= `PCAS_RST_CLK_SEL;
      prescale_q <= `PCAS_RST_PRESCALE;
      align_q    <= `PCAS_RST_ALIGN;
      scale_a_q  <= `PCAS_RST_SCALE;
      scale_b_q  <= `PCAS_RST_SCALE;
      join_q     <= `PCAS_RST_PAIR_JOIN;
      rdat_q     <= 32'h00000000;
      err_q      <= 1'b0;
    end else begin
      bus_q      <= bus_d;
      src_sel_q  <= src_sel_d;
      prescale_q <= prescale_d;
      align_q    <= align_d;
      scale_a_q  <= scale_a_d;
      scale_b_q  <= scale_b_d;
      join_q     <= join_d;
      rdat_q     <= rdat_d;
      err_q      <= err_d;
    end
  end

  // answer: ack for mapped words, err for the rest
  always_comb begin
    ack_o           = (bus_q == PCAS_BUS_ACK) && !err_q;
    err_o           = (bus_q == PCAS_BUS_ACK) && err_q;
    dat_o           = rdat_q;
    pair_join_bit_o = join_q;
  end

  // clock a and clock b dividers
  pcas_prescaler u_prescaler (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .code_a_i (prescale_q[`PCAS_PRE_A_LSB +: 3]),
    .code_b_i (prescale_q[`PCAS_PRE_B_LSB +: 3]),
    .tick_a_o (tick_a),
    .tick_b_o (tick_b)
  );

  // scaled clocks
  pcas_scaler u_scale_a (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick_a),
    .scale_i  (scale_a_d), // a reload takes the value being written, not the old one
    .reload_i (wr_a),
    .tick_o   (tick_sa)
  );

  pcas_scaler u_scale_b (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick_b),
    .scale_i  (scale_b_d), // reload takes the value being written
    .reload_i (wr_b),
    .tick_o   (tick_sb)
  );

  // per-channel clock and alignment; joined pairs take the odd channel's bits
  for (genvar n = 0; n < 8; n++) begin : g_chan
    localparam int PAIR = n / 2;
    localparam int ODD  = n | 1;
    localparam logic [7:0] GRP_B_MAP = `PCAS_GROUP_B_MAP;
    localparam logic       IS_B      = GRP_B_MAP[n];
    logic sel_bit;
    logic center_bit;
    always_comb begin
      sel_bit    = join_q[PAIR] ? src_sel_q[ODD] : src_sel_q[n];
      center_bit = join_q[PAIR] ? align_q[ODD] : align_q[n];
      if (IS_B) begin
        ctl[n].clk_tick = sel_bit ? tick_sb : tick_b;
      end else begin
        ctl[n].clk_tick = sel_bit ? tick_sa : tick_a;
      end
      ctl[n].center = center_bit;
    end
    always_comb begin
      chan_tick_o[n]   = ctl[n].clk_tick;
      chan_center_o[n] = ctl[n].center;
    end
  end

endmodule : pcas_clock_align
`default_nettype wire

// file: rtl/pcas_pkg.sv
package pcas_pkg;

  // one channel's resolved control as seen by the channel logic
  typedef struct packed {
    logic clk_tick;
    logic center;
  } pcas_chan_ctl_t;

  // wishbone request carried as one word
  typedef struct packed {
    logic [7:0]  adr;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pcas_wb_req_t;

  typedef enum logic [0:0] {
    PCAS_BUS_IDLE = 1'b0,
    PCAS_BUS_ACK  = 1'b1
  } pcas_bus_state_t;

endpackage : pcas_pkg

// file: rtl/pcas_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// free-running power-of-two divider giving one-cycle ticks for clocks a and b
module pcas_prescaler
  import pcas_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] code_a_i,
  input  wire logic [2:0] code_b_i,
  output logic            tick_a_o,
  output logic            tick_b_o
);

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [7:0] mask_a;
  logic [7:0] mask_b;

  // counter next value
  always_comb begin
    cnt_d = cnt_q + 7'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // tick when the low code bits of the counter are all ones; new code acts at once
  always_comb begin
    mask_a   = (8'h01 << code_a_i) - 8'h01;
    mask_b   = (8'h01 << code_b_i) - 8'h01;
    tick_a_o = ((cnt_q & mask_a[6:0]) == mask_a[6:0]);
    tick_b_o = ((cnt_q & mask_b[6:0]) == mask_b[6:0]);
  end

endmodule : pcas_prescaler
`default_nettype wire

// file: rtl/pcas_regs.svh
`ifndef PCAS_REGS_SVH
`define PCAS_REGS_SVH

// register byte addresses (one aligned word each)
`define PCAS_ADDR_CLK_SEL     8'h00
`define PCAS_ADDR_PRESCALE    8'h04
`define PCAS_ADDR_ALIGN       8'h08
`define PCAS_ADDR_SCALE_A     8'h0C
`define PCAS_ADDR_SCALE_B     8'h10
`define PCAS_ADDR_PAIR_JOIN   8'h14

// prescale field positions
`define PCAS_PRE_A_LSB        0
`define PCAS_PRE_B_LSB        4
`define PCAS_PRE_MASK         8'h77

// reset values
`define PCAS_RST_CLK_SEL      8'h00
`define PCAS_RST_PRESCALE     8'h00
`define PCAS_RST_ALIGN        8'h00
`define PCAS_RST_SCALE        8'h00
`define PCAS_RST_PAIR_JOIN    4'h0

// group membership: 1 marks a channel fed from group B
`define PCAS_GROUP_B_MAP      8'hCC

`endif

// file: rtl/pcas_scaler.sv
`timescale 1ns/1ps
`default_nettype none
// divides an input tick by twice the scale value; zero counts as 256
module pcas_scaler
  import pcas_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic [7:0] scale_i,
  input  wire logic       reload_i,
  output logic            tick_o
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic [8:0] span;

  // count 2*scale input ticks, reload on any scale write
  always_comb begin
    span   = {1'b0, scale_i} << 1;
    if (scale_i == 8'h00) begin
      span = 9'h000; // wraps through 512 ticks
    end
    tick_o = tick_i && (cnt_q == 9'h001);
    cnt_d  = cnt_q;
    if (reload_i) begin
      cnt_d = span;
    end else if (tick_i) begin
      cnt_d = (cnt_q == 9'h001) ? span : cnt_q - 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : pcas_scaler
`default_nettype wire
